// file: core/byte_ram.sv
// Small 32 x 8 memory with registered read data
module byte_ram (
	input wire logic clk_i, // Clock
	input wire logic we_i, // Write enable
	input wire logic [4:0] waddr_i, // Write address
	input wire logic [7:0] wdata_i, // Write data
	input wire logic [4:0] raddr_i, // Read address
	output logic [7:0] rdata_o // Read data, one cycle later
);
	logic [7:0] mem [32];

	// ------------------------------------------------------------
	// Storage; no reset, contents are undefined until written
	// ------------------------------------------------------------
	always_ff @(posedge clk_i) begin
		if (we_i) begin
			mem[waddr_i] <= wdata_i;
		end
		rdata_o <= mem[raddr_i];
	end
endmodule // byte_ram

// file: core/hwmon_core.sv
// Supervisory core of the hardware monitor: sequencer, limits, status, resets, fan outputs
//
// Overview of operation
// R1: When running, the sequencer walks the analog and temperature channels; fans count apart.
// R2: A pass is 18 short conversions of 11.38 ms and 2 long remote-diode ones of 34.13 ms.
// R3: Each 8-bit result goes into its channel's value register, readable by the host.
// R4: Each result is checked against its high and low limits and a miss sets its status bit.
// R5: An unmasked set status bit pulls the active-low interrupt output low.
// R6: Every status bit has its own mask bit and a masked one never reaches the interrupt.
// R7: Fan period is taken over two tachometer pulses, one fan revolution.
// R8: A chassis intrusion is latched in a battery-held bit until software clears it.
// R9: Each rail reset output is asserted while its 3.3 V rail detector reports low.
// R10: Each rail reset is held for 180 ms after power-up before release.
// R11: An outside low level on the main reset pin is taken as a reset request.
// R12: The fan PWM output is open drain at 75 Hz with a programmed duty.
// R13: The fan DAC code is an 8-bit value written by the host and held.
// R14: Each access loads its register address into the address pointer.
// R15: The second remote input is either a diode channel or a 0 V to 2.5 V analog channel.
// R16: Fan pins are tach inputs or GPIO; the alarm pin is GPIO or a two-way thermal alarm. The alarm pin GPIO is output only; its level is not readable.
// R17: After the last channel the sequencer loops to the first until stopped.
//
// Local design decisions: strobed register access and the register addresses.
`include "hwmon_map.svh"
module hwmon_core import hwmon_pkg::*; #(
	parameter int unsigned SHORT_CYC = `T_SHORT_US * `CLK_MHZ, // Short conversion
	parameter int unsigned LONG_CYC = `T_LONG_US * `CLK_MHZ, // Remote diode conversion
	parameter int unsigned RST_CYC = `T_RST_US * `CLK_MHZ, // Power-up reset pulse
	parameter int unsigned PWM_DIV = `CLK_HZ / (`F_PWM_HZ * 256), // PWM step
	parameter int unsigned TACH_DIV = `CLK_HZ / `F_TACH_HZ // Tach count tick
) (
	input wire logic mclk_i, // System clock
	input wire logic rst_i, // Asynchronous reset, active high
	input wire logic vbat_rst_i, // Battery domain reset, active high
	input wire logic [7:0] addr_i, // Register address
	input wire logic [7:0] wdata_i, // Write data
	input wire logic wr_i, // Write strobe
	input wire logic rd_i, // Read strobe
	output logic [7:0] rdata_o, // Read data, cycle after the strobe
	output adc_req_t adc_o, // Converter request
	input wire logic [7:0] adc_data_i, // Converter result
	input wire logic [7:0] fan_io_i, // Fan / GPIO pin levels
	output logic [7:0] fan_io_o, // Fan / GPIO pin drive value
	output logic [7:0] fan_io_oe_o, // Fan / GPIO pin drive enable
	input wire logic thermal_alarm_pin_i, // Alarm pin level
	output logic thermal_alarm_pin_o, // Alarm pin drive value
	output logic thermal_alarm_pin_oe_o, // Alarm pin drive enable
	input wire logic chassis_intrusion_i, // Intrusion switch, high on event
	input wire logic main_low_i, // Main 3.3 V rail below threshold
	input wire logic stby_low_i, // Standby 3.3 V rail below threshold
	input wire logic main_rail_reset_n_i, // Main reset pin level
	output logic main_rail_reset_n_o, // Main reset pin drive value
	output logic main_rail_reset_n_oe_o, // Main reset pin drive enable
	output logic standby_rail_reset_n_o, // Standby reset, active low
	output logic fan_pwm_o, // PWM pin drive value
	output logic fan_pwm_oe_o, // PWM pin drive enable
	output logic [7:0] dac_code_o, // Fan DAC code
	output logic int_n_o // Interrupt, active low
);
	localparam logic [25:0] SHORT_N = 26'(SHORT_CYC - 1);
	localparam logic [25:0] LONG_N = 26'(LONG_CYC - 1);
	localparam logic [25:0] RST_N = 26'(RST_CYC - 1);
	localparam logic [15:0] PWM_N = 16'(PWM_DIV - 1);
	localparam logic [15:0] TACH_N = 16'(TACH_DIV - 1);

	// Saturating 8-bit increment
	function automatic logic [7:0] sat_inc(input logic [7:0] v);
		return (v == 8'hFF) ? v : v + 8'h01;
	endfunction

	// ------------------------------------------------------------
	// Input synchronisers
	// ------------------------------------------------------------
	logic [7:0] adc_m, adc_s, fan_m, fan_s, fan_d;
	logic [5:0] pin_m, pin_s;
	always_ff @(posedge mclk_i or posedge rst_i) begin
		if (rst_i) begin
			adc_m <= 8'h00;
			adc_s <= 8'h00;
			fan_m <= 8'h00;
			fan_s <= 8'h00;
			fan_d <= 8'h00;
			pin_m <= 6'h13;
			pin_s <= 6'h13;
		end else begin
			adc_m <= adc_data_i;
			adc_s <= adc_m;
			fan_m <= fan_io_i;
			fan_s <= fan_m;
			fan_d <= fan_s;
			pin_m <= {stby_low_i, main_rail_reset_n_i, main_low_i,
				chassis_intrusion_i, thermal_alarm_pin_i, 1'b1};
			pin_s <= pin_m;
		end
	end
	logic thermal_alarm_pin_s, ci_s, main_low_s, main_pin_s, stby_low_s, ci_d;
	assign thermal_alarm_pin_s = pin_s[1];
	assign ci_s = pin_s[2];
	assign main_low_s = pin_s[3];
	assign main_pin_s = pin_s[4];
	assign stby_low_s = pin_s[5];

	// ------------------------------------------------------------
	// Control registers
	// ------------------------------------------------------------
	logic [7:0] cfg, fancfg, pwm_duty, ptr, gpout, gpoe;
	logic [31:0] mask;
	logic [7:0] fan_lim [8];
	logic [2:0] rgn;
	logic [4:0] idx;
	assign rgn = addr_i[7:5];
	assign idx = addr_i[4:0];
	always_ff @(posedge mclk_i or posedge rst_i) begin
		if (rst_i) begin
			cfg <= `CFG_RST;
			fancfg <= `FANCFG_RST;
			pwm_duty <= `PWM_RST;
			dac_code_o <= `DAC_RST;
			mask <= `MASK_RST;
			ptr <= 8'h00;
			gpout <= 8'h00;
			gpoe <= 8'h00;
			for (int i = 0; i < 8; i++) begin
				fan_lim[i] <= `FANLIM_RST;
			end
		end else begin
			if (wr_i || rd_i) begin
				ptr <= addr_i; // [R14]
			end
			if (wr_i) begin
				case (addr_i)
					`A_CFG: cfg <= wdata_i;
					`A_FANCFG: fancfg <= wdata_i;
					`A_PWM: pwm_duty <= wdata_i;
					`A_DAC: dac_code_o <= wdata_i; // [R13]
					`A_GPOUT: gpout <= wdata_i;
					`A_GPOE: gpoe <= wdata_i;
					default: begin
						if (addr_i[7:2] == `A_MASK0 >> 2) begin
							mask[8*addr_i[1:0] +: 8] <= wdata_i; // [R6]
						end
						if (rgn == `RG_HI && idx >= `IDX_FAN0) begin
							fan_lim[idx[2:0]] <= wdata_i;
						end
					end
				endcase
			end
		end
	end

	// ------------------------------------------------------------
	// Value and limit storage
	// ------------------------------------------------------------
	seq_state_t st;
	logic [4:0] ch;
	logic [7:0] val_q, hi_q, lo_q;
	logic lim_we_hi, lim_we_lo;
	logic [4:0] lim_ra;
	assign lim_we_hi = wr_i && rgn == `RG_HI && idx <= `CH_LAST;
	assign lim_we_lo = wr_i && rgn == `RG_LO && idx <= `CH_LAST;
	// The host read wins the limit read port; the sequencer waits in S_STORE
	assign lim_ra = rd_i ? idx : ch;
	byte_ram u_val (
		.clk_i(mclk_i),
		.we_i(st == S_STORE), // [R3]
		.waddr_i(ch),
		.wdata_i(adc_s),
		.raddr_i(idx),
		.rdata_o(val_q)
	);
	byte_ram u_hi (
		.clk_i(mclk_i),
		.we_i(lim_we_hi),
		.waddr_i(idx),
		.wdata_i(wdata_i),
		.raddr_i(lim_ra),
		.rdata_o(hi_q)
	);
	byte_ram u_lo (
		.clk_i(mclk_i),
		.we_i(lim_we_lo),
		.waddr_i(idx),
		.wdata_i(wdata_i),
		.raddr_i(lim_ra),
		.rdata_o(lo_q)
	);

	// ------------------------------------------------------------
	// Measurement sequencer
	// ------------------------------------------------------------
	logic [25:0] conv_cnt;
	logic [7:0] cur_val;
	logic long_ch;
	// Remote 1 is always a diode; remote 2 only when not set as analog
	assign long_ch = (ch == `CH_REM1) || (ch == `CH_LAST && !cfg[`CFG_R2ANA]); // [R15]
	always_ff @(posedge mclk_i or posedge rst_i) begin
		if (rst_i) begin
			st <= S_IDLE;
			ch <= 5'h00;
			conv_cnt <= 26'h0;
			cur_val <= 8'h00;
			adc_o <= '0;
		end else begin
			adc_o.start <= 1'b0;
			case (st)
				S_IDLE: begin
					ch <= 5'h00;
					if (cfg[`CFG_RUN]) begin
						st <= S_START; // [R1]
					end
				end
				S_START: begin
					adc_o.start <= 1'b1;
					adc_o.chan <= ch;
					adc_o.diode <= long_ch;
					conv_cnt <= long_ch ? LONG_N : SHORT_N; // [R2]
					st <= S_CONV;
				end
				S_CONV: begin
					if (conv_cnt == 26'h0) begin
						st <= S_STORE;
					end else begin
						conv_cnt <= conv_cnt - 26'h1;
					end
				end
				S_STORE: begin
					cur_val <= adc_s;
					if (!rd_i) begin
						st <= S_CMP;
					end
				end
				S_CMP: begin
					ch <= (ch == `CH_LAST) ? 5'h00 : ch + 5'h01; // [R17]
					st <= cfg[`CFG_RUN] ? S_START : S_IDLE;
				end
				default: st <= S_IDLE;
			endcase
		end
	end

	// ------------------------------------------------------------
	// Fan tachometers: period of two pulses in ticks
	// ------------------------------------------------------------
	logic [15:0] tach_div;
	logic tach_tick;
	logic [7:0] fan_cnt [8];
	logic [7:0] fan_val [8];
	logic [7:0] fan_half, fan_ev;
	assign tach_tick = (tach_div == 16'h0);
	always_ff @(posedge mclk_i or posedge rst_i) begin
		if (rst_i) begin
			tach_div <= 16'h0;
			fan_half <= 8'h00;
			fan_ev <= 8'h00;
			for (int i = 0; i < 8; i++) begin
				fan_cnt[i] <= 8'h00;
				fan_val[i] <= 8'hFF;
			end
		end else begin
			tach_div <= tach_tick ? TACH_N : tach_div - 16'h1;
			for (int i = 0; i < 8; i++) begin
				fan_ev[i] <= 1'b0;
				if (fancfg[i] || !cfg[`CFG_RUN]) begin
					fan_cnt[i] <= 8'h00;
					fan_half[i] <= 1'b0;
				end else if (fan_s[i] && !fan_d[i]) begin
					fan_half[i] <= !fan_half[i];
					if (fan_half[i]) begin
						fan_val[i] <= fan_cnt[i]; // [R7]
						fan_cnt[i] <= 8'h00;
						fan_ev[i] <= fan_cnt[i] > fan_lim[i];
					end
				end else if (tach_tick) begin
					fan_cnt[i] <= sat_inc(fan_cnt[i]);
					// A stopped fan saturates and reports full scale
					if (fan_cnt[i] == 8'hFF) begin
						fan_val[i] <= 8'hFF;
						fan_ev[i] <= 8'hFF > fan_lim[i];
					end
				end
			end
		end
	end

	// ------------------------------------------------------------
	// Status, mask and interrupt
	// ------------------------------------------------------------
	logic [31:0] stat, ev, clr, stat_all;
	logic ci_flag;
	always_comb begin
		ev = 32'h0;
		if (st == S_CMP && (cur_val > hi_q || cur_val < lo_q)) begin
			ev[ch] = 1'b1; // [R4]
		end
		ev[`ST_FAN0 +: 8] = fan_ev;
		ev[`ST_THERMAL_ALARM_PIN] = cfg[`CFG_THERMAL_ALARM_PIN] && !thermal_alarm_pin_s && !thermal_alarm_pin_oe_o;
		clr = 32'h0;
		if (wr_i && addr_i[7:2] == `A_STAT0 >> 2) begin
			clr[8*addr_i[1:0] +: 8] = wdata_i;
		end
	end
	// Set wins over a clear in the same cycle
	always_ff @(posedge mclk_i or posedge rst_i) begin
		if (rst_i) begin
			stat <= 32'h0;
		end else begin
			stat <= (stat & ~clr) | ev;
		end
	end
	// Intrusion bit sits on the battery domain reset only
	always_ff @(posedge mclk_i or posedge vbat_rst_i) begin
		if (vbat_rst_i) begin
			ci_d <= 1'b0;
			ci_flag <= 1'b0;
		end else begin
			ci_d <= ci_s;
			ci_flag <= (ci_flag && !clr[`ST_CI]) || (ci_s && !ci_d); // [R8]
		end
	end
	always_comb begin
		stat_all = stat;
		stat_all[`ST_CI] = ci_flag;
	end
	assign int_n_o = !(|(stat_all & ~mask)); // [R5] [R6]

	// ------------------------------------------------------------
	// Rail resets with power-up stretch
	// ------------------------------------------------------------
	logic [25:0] main_cnt, stby_cnt;
	logic main_act, stby_act, ext_req;
	logic [1:0] drv_sh;
	// Our own drive reads back two flops late, so a low counts as outside only after that
	assign ext_req = !main_pin_s && !main_act && !(|drv_sh); // [R11]
	always_ff @(posedge mclk_i or posedge rst_i) begin
		if (rst_i) begin
			main_cnt <= RST_N;
			stby_cnt <= RST_N;
			main_act <= 1'b1;
			stby_act <= 1'b1;
			drv_sh <= 2'b11;
		end else begin
			drv_sh <= {drv_sh[0], main_act};
			if (main_low_s || ext_req) begin
				main_cnt <= RST_N; // [R9]
				main_act <= 1'b1;
			end else if (main_cnt != 26'h0) begin
				main_cnt <= main_cnt - 26'h1; // [R10]
			end else begin
				main_act <= 1'b0;
			end
			if (stby_low_s) begin
				stby_cnt <= RST_N; // [R9]
				stby_act <= 1'b1;
			end else if (stby_cnt != 26'h0) begin
				stby_cnt <= stby_cnt - 26'h1; // [R10]
			end else begin
				stby_act <= 1'b0;
			end
		end
	end
	assign main_rail_reset_n_o = 1'b0;
	assign main_rail_reset_n_oe_o = main_act;
	assign standby_rail_reset_n_o = !stby_act;

	// ------------------------------------------------------------
	// Fan PWM, 256 steps per 75 Hz period
	// ------------------------------------------------------------
	logic [15:0] pwm_div;
	logic [7:0] pwm_ph;
	always_ff @(posedge mclk_i or posedge rst_i) begin
		if (rst_i) begin
			pwm_div <= 16'h0;
			pwm_ph <= 8'h00;
			fan_pwm_oe_o <= 1'b0;
		end else begin
			pwm_div <= (pwm_div == 16'h0) ? PWM_N : pwm_div - 16'h1;
			if (pwm_div == 16'h0) begin
				pwm_ph <= pwm_ph + 8'h01;
			end
			// Duty 8'hFF keeps the pin released for the whole period
			fan_pwm_oe_o <= (pwm_duty != 8'hFF) && (pwm_ph >= pwm_duty); // [R12]
		end
	end
	assign fan_pwm_o = 1'b0;

	// ------------------------------------------------------------
	// Pin mode selection
	// ------------------------------------------------------------
	assign fan_io_o = gpout;
	assign fan_io_oe_o = gpoe & fancfg; // [R16]
	assign thermal_alarm_pin_o = cfg[`CFG_THERMAL_ALARM_PIN] ? 1'b0 : cfg[`CFG_TGPO];
	assign thermal_alarm_pin_oe_o = cfg[`CFG_THERMAL_ALARM_PIN] ?
		(|stat[`CH_LAST:`CH_LTEMP]) : cfg[`CFG_TGOE]; // [R16]

	// ------------------------------------------------------------
	// Read data: registered select, memories already registered
	// ------------------------------------------------------------
	logic [1:0] rsel;
	logic [7:0] rreg;
	always_ff @(posedge mclk_i or posedge rst_i) begin
		if (rst_i) begin
			rsel <= 2'd0;
			rreg <= 8'h00;
		end else if (rd_i) begin
			rsel <= 2'd0;
			rreg <= 8'h00;
			if (rgn >= `RG_VAL && rgn <= `RG_LO && idx <= `CH_LAST) begin
				rsel <= rgn[1:0];
			end else if (rgn == `RG_VAL && idx >= `IDX_FAN0) begin
				rreg <= fan_val[idx[2:0]];
			end else if (rgn == `RG_HI && idx >= `IDX_FAN0) begin
				rreg <= fan_lim[idx[2:0]];
			end else if (addr_i[7:2] == `A_STAT0 >> 2) begin
				rreg <= stat_all[8*addr_i[1:0] +: 8];
			end else if (addr_i[7:2] == `A_MASK0 >> 2) begin
				rreg <= mask[8*addr_i[1:0] +: 8];
			end else begin
				case (addr_i)
					`A_CFG: rreg <= cfg;
					`A_FANCFG: rreg <= fancfg;
					`A_PWM: rreg <= pwm_duty;
					`A_DAC: rreg <= dac_code_o;
					`A_PTR: rreg <= ptr;
					`A_GPIN: rreg <= fan_s;
					`A_GPOUT: rreg <= gpout;
					`A_GPOE: rreg <= gpoe;
					default: rreg <= 8'h00;
				endcase
			end
		end
	end
	always_comb begin
		case (rsel)
			2'd1: rdata_o = val_q;
			2'd2: rdata_o = hi_q;
			2'd3: rdata_o = lo_q;
			default: rdata_o = rreg;
		endcase
	end
endmodule // hwmon_core

// file: core/hwmon_map.svh
// Register offsets, field positions, reset values and timing figures of the monitor core
`ifndef HWMON_MAP_SVH
`define HWMON_MAP_SVH
// ----------------------------------------------------------------
// Register offsets (byte wide registers)
// ----------------------------------------------------------------
`define A_CFG 8'h00
`define A_FANCFG 8'h01
`define A_PWM 8'h02
`define A_DAC 8'h03
`define A_STAT0 8'h04
`define A_MASK0 8'h08
`define A_PTR 8'h0C
`define A_GPIN 8'h0D
`define A_GPOUT 8'h0E
`define A_GPOE 8'h0F
`define RG_VAL 3'h1
`define RG_HI 3'h2
`define RG_LO 3'h3
`define IDX_FAN0 5'h18
// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define CFG_RUN 0
`define CFG_R2ANA 1
`define CFG_THERMAL_ALARM_PIN 2
`define CFG_TGPO 3
`define CFG_TGOE 4
`define ST_FAN0 20
`define ST_CI 28
`define ST_THERMAL_ALARM_PIN 29
`define CH_LTEMP 5'h11
`define CH_REM1 5'h12
`define CH_LAST 5'h13
// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define CFG_RST 8'h00
`define FANCFG_RST 8'h00
`define PWM_RST 8'hFF
`define DAC_RST 8'h00
`define MASK_RST 32'h0000_0000
`define FANLIM_RST 8'hFF
// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define CLK_MHZ 250
`define CLK_HZ 250000000
`define T_SHORT_US 11380
`define T_LONG_US 34130
`define T_RST_US 180000
`define F_PWM_HZ 75
`define F_TACH_HZ 22500
`endif

// file: core/hwmon_pkg.sv
// Types shared by the monitor core files
package hwmon_pkg;
	// Request to the analog front end
	typedef struct packed {
		logic start;
		logic [4:0] chan;
		logic diode;
	} adc_req_t;
	// Open-drain or two-way pin drive
	typedef struct packed {
		logic o;
		logic oe;
	} pin_drv_t;
	typedef enum logic [2:0] {
		S_IDLE = 3'b000,
		S_START = 3'b001,
		S_CONV = 3'b010,
		S_STORE = 3'b011,
		S_CMP = 3'b100
	} seq_state_t;
endpackage

// file: dv/hwmon_afe_model.sv
// Behavioural converter front end and fan tachometers facing the core
module hwmon_afe_model import hwmon_pkg::*; (
	input wire logic clk_i, // Core clock
	input wire adc_req_t req_i, // Conversion request
	output logic [7:0] data_o, // Conversion result
	output logic [7:0] tach_o // Tach pulses
);
	timeunit 1ns;
	timeprecision 100ps;
	// Old code is inverted while converting, so an early sample reads wrong
	initial begin
		data_o = 8'h00;
		forever begin
			@(posedge clk_i);
			if (req_i.start) begin
				data_o <= ~data_o;
				repeat (2) @(posedge clk_i);
				data_o <= (req_i.chan == 5'h03) ? 8'hF0 : 8'h20 + {3'h0, req_i.chan};
			end
		end
	end
	// Two pulses per fan turn, 32 ns period on every fan pin
	initial begin
		tach_o = 8'h00;
		forever #16 tach_o = ~tach_o;
	end
endmodule // hwmon_afe_model

// file: dv/hwmon_core_sva.sv
// Port-level assertions for the monitor core
`include "hwmon_map.svh"
module hwmon_core_sva import hwmon_pkg::*; (
	input wire logic mclk_i, // Clock
	input wire logic rst_i, // Reset
	input wire logic [7:0] addr_i, // Address
	input wire logic [7:0] wdata_i, // Write data
	input wire logic wr_i, // Write strobe
	input wire logic rd_i, // Read strobe
	input wire logic [7:0] rdata_o, // Read data
	input wire adc_req_t adc_o, // Converter request
	input wire logic main_low_i, // Main rail low
	input wire logic stby_low_i, // Standby rail low
	input wire logic main_rail_reset_n_i, // Main reset pin
	input wire logic main_rail_reset_n_oe_o, // Main reset drive
	input wire logic standby_rail_reset_n_o, // Standby reset
	input wire logic fan_pwm_o, // PWM value
	input wire logic fan_pwm_oe_o, // PWM drive
	input wire logic [7:0] dac_code_o, // DAC code
	input wire logic int_n_o // Interrupt
);
	default clocking @(posedge mclk_i); endclocking
	default disable iff (rst_i);
	logic [31:0] mask_sh;
	logic [4:0] last_ch;
	logic [4:0] next_ch;
	logic seen;
	logic go;
	// Mask shadow built from host writes, so masking is judged from ports alone
	always_ff @(posedge mclk_i or posedge rst_i) begin
		if (rst_i) begin
			mask_sh <= 32'h0000_0000;
		end else if (wr_i && addr_i[7:2] == 6'h02) begin
			mask_sh[{addr_i[1:0], 3'h0} +: 8] <= wdata_i;
		end
	end
	// Channel taken a cycle after start, so p_order still compares against the previous conversion
	always_ff @(posedge mclk_i or posedge rst_i) begin
		if (rst_i) begin
			go <= 1'b0;
			seen <= 1'b0;
			last_ch <= 5'h00;
		end else begin
			go <= adc_o.start;
			if (go) begin
				seen <= 1'b1;
				last_ch <= adc_o.chan;
			end
		end
	end
	assign next_ch = (last_ch == `CH_LAST) ? 5'h00 : last_ch + 5'h01;
	sequence s_dac_wr; wr_i && addr_i == `A_DAC; endsequence
	sequence s_pwm_off; wr_i && addr_i == `A_PWM && wdata_i == 8'hFF; endsequence
	property p_dac_load; s_dac_wr |=> dac_code_o == $past(wdata_i); endproperty
	a_dac_load: assert property (p_dac_load) else $error("dac code not loaded");
	property p_dac_hold; !(wr_i && addr_i == `A_DAC) |=> $stable(dac_code_o); endproperty
	a_dac_hold: assert property (p_dac_hold) else $error("dac code moved");
	property p_pwm_off; s_pwm_off |-> ##3 !fan_pwm_oe_o [*8]; endproperty
	a_pwm_off: assert property (p_pwm_off) else $error("pwm driven at full duty");
	property p_pwm_od; fan_pwm_o == 1'b0; endproperty
	a_pwm_od: assert property (p_pwm_od) else $error("pwm drives high");
	property p_gap; adc_o.start |=> !adc_o.start [*8]; endproperty
	a_gap: assert property (p_gap) else $error("conversions too close");
	property p_order; adc_o.start && seen |=> adc_o.chan == next_ch; endproperty
	a_order: assert property (p_order) else $error("channel out of order");
	property p_diode; adc_o.start && adc_o.chan == `CH_REM1 |=> adc_o.diode; endproperty
	a_diode: assert property (p_diode) else $error("remote one not diode");
	property p_mask; &mask_sh |-> int_n_o; endproperty
	a_mask: assert property (p_mask) else $error("masked interrupt seen");
	property p_main; main_low_i |-> ##[1:4] main_rail_reset_n_oe_o; endproperty
	a_main: assert property (p_main) else $error("main reset late");
	property p_stby; stby_low_i |-> ##[1:4] !standby_rail_reset_n_o; endproperty
	a_stby: assert property (p_stby) else $error("standby reset late");
	property p_ext; !main_rail_reset_n_i && !main_rail_reset_n_oe_o |->
		##[1:4] main_rail_reset_n_oe_o;
	endproperty
	a_ext: assert property (p_ext) else $error("outside reset ignored");
	property p_rel; $rose(standby_rail_reset_n_o) |-> $past(standby_rail_reset_n_o, 8) == 1'b0;
	endproperty
	a_rel: assert property (p_rel) else $error("standby pulse short");
	property p_unmap; rd_i && addr_i == 8'h10 |=> rdata_o == 8'h00; endproperty
	a_unmap: assert property (p_unmap) else $error("unmapped read not zero");
endmodule // hwmon_core_sva
bind hwmon_core hwmon_core_sva u_hwmon_core_sva (.mclk_i, .rst_i, .addr_i, .wdata_i, .wr_i,
	.rd_i, .rdata_o, .adc_o, .main_low_i, .stby_low_i, .main_rail_reset_n_i,
	.main_rail_reset_n_oe_o, .standby_rail_reset_n_o, .fan_pwm_o, .fan_pwm_oe_o,
	.dac_code_o, .int_n_o);

// file: dv/tb_top.sv
// Self-checking bench of the monitor core
`include "hwmon_map.svh"
module tb_top import hwmon_pkg::*; ;
	timeunit 1ns;
	timeprecision 100ps;
	typedef struct {logic [7:0] a; logic [7:0] d; logic w; logic [7:0] e;} row_t;
	logic mclk_i, rst_i, vbat_rst_i, wr_i, rd_i, ci_i, main_low_i, stby_low_i, ext_n;
	logic [7:0] addr_i, wdata_i, rdata_o, adc_data, tach, fan_o, fan_oe, dac, v;
	logic alarm_o, alarm_oe, main_o, main_oe, stby_n, pwm_o, pwm_oe, int_n;
	logic [31:0] cnt;
	adc_req_t adc;
	int n_errors = 0;
	int cmp_count = 0;
	// Open-drain and two-way pin levels from all drivers, pull-ups assumed
	wire main_pin = ext_n & ~(main_oe & ~main_o);
	wire alarm_pin = alarm_oe ? alarm_o : 1'b1;
	wire [7:0] fan_pin = (fan_oe & fan_o) | (~fan_oe & tach);
	row_t rows [11] = '{
		'{`A_CFG, 8'h00, 1'b0, `CFG_RST}, '{`A_FANCFG, 8'h00, 1'b0, `FANCFG_RST},
		'{`A_PWM, 8'h00, 1'b0, `PWM_RST}, '{`A_DAC, 8'h00, 1'b0, `DAC_RST},
		'{`A_MASK0, 8'h00, 1'b0, 8'h00}, '{8'h10, 8'h00, 1'b0, 8'h00},
		'{`A_DAC, 8'h5A, 1'b1, 8'h5A}, '{8'h10, 8'hA5, 1'b1, 8'h00},
		'{`A_GPOUT, 8'h3C, 1'b1, 8'h3C}, '{8'h09, 8'h55, 1'b1, 8'h55},
		'{`A_PTR, 8'h00, 1'b0, 8'h09}};
	hwmon_core #(.SHORT_CYC(20), .LONG_CYC(40), .RST_CYC(50), .PWM_DIV(2), .TACH_DIV(4))
		u_hwmon_core (
		.mclk_i(mclk_i), .rst_i(rst_i), .vbat_rst_i(vbat_rst_i), .addr_i(addr_i),
		.wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .adc_o(adc),
		.adc_data_i(adc_data), .fan_io_i(fan_pin), .fan_io_o(fan_o), .fan_io_oe_o(fan_oe),
		.thermal_alarm_pin_i(alarm_pin), .thermal_alarm_pin_o(alarm_o),
		.thermal_alarm_pin_oe_o(alarm_oe), .chassis_intrusion_i(ci_i), .main_low_i(main_low_i),
		.stby_low_i(stby_low_i), .main_rail_reset_n_i(main_pin), .main_rail_reset_n_o(main_o),
		.main_rail_reset_n_oe_o(main_oe), .standby_rail_reset_n_o(stby_n), .fan_pwm_o(pwm_o),
		.fan_pwm_oe_o(pwm_oe), .dac_code_o(dac), .int_n_o(int_n));
	hwmon_afe_model u_hwmon_afe_model (.clk_i(mclk_i), .req_i(adc), .data_o(adc_data),
		.tach_o(tach));
	// 250 MHz core clock
	initial begin
		mclk_i = 1'b0;
		forever #2 mclk_i = ~mclk_i;
	end
	task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
		cmp_count++;
		if (got !== exp) begin
			n_errors++;
			$display("MISMATCH t=%0t %s got %h exp %h", $time, what, got, exp);
		end
	endtask
	// Host bus cycles: strobe one cycle, then one idle cycle
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge mclk_i);
		addr_i <= a;
		wdata_i <= d;
		wr_i <= 1'b1;
		@(posedge mclk_i);
		wr_i <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		@(posedge mclk_i);
		addr_i <= a;
		rd_i <= 1'b1;
		@(posedge mclk_i);
		rd_i <= 1'b0;
		@(posedge mclk_i);
		d = rdata_o;
	endtask
	task automatic finish_test();
		$display("compares %0d mismatches %0d", cmp_count, n_errors);
		if (n_errors == 0 && cmp_count > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask
	// Watchdog well past the roughly 1700 cycles the tests need
	initial begin
		repeat (20000) @(posedge mclk_i);
		n_errors++;
		$display("MISMATCH t=%0t watchdog expired", $time);
		finish_test();
	end
	// Main sequence
	initial begin
		{rst_i, vbat_rst_i, ext_n} = 3'b111;
		{wr_i, rd_i, ci_i, main_low_i, stby_low_i} = 5'h00;
		{addr_i, wdata_i} = 16'h0000;
		repeat (4) @(posedge mclk_i);
		rst_i <= 1'b0;
		vbat_rst_i <= 1'b0;
		repeat (10) @(posedge mclk_i);
		check({stby_n, main_oe}, 2'b01, "pulse held");
		repeat (60) @(posedge mclk_i);
		check({stby_n, main_oe}, 2'b10, "pulse ends");
		stby_low_i <= 1'b1;
		main_low_i <= 1'b1;
		repeat (5) @(posedge mclk_i);
		check({stby_n, main_oe}, 2'b01, "rail low");
		{stby_low_i, main_low_i} <= 2'b00;
		repeat (60) @(posedge mclk_i);
		ext_n <= 1'b0;
		repeat (3) @(posedge mclk_i);
		ext_n <= 1'b1;
		repeat (2) @(posedge mclk_i);
		check(main_oe, 1'b1, "outside reset");
		repeat (60) @(posedge mclk_i);
		$display("test rails done");
		foreach (rows[i]) begin
			if (rows[i].w) wr(rows[i].a, rows[i].d);
			rd(rows[i].a, v);
			check(v, rows[i].e, "register");
		end
		check(dac, 8'h5A, "dac pin");
		$display("test registers done");
		for (int c = 0; c < 20; c++) begin
			wr(8'h40 + 8'(c), 8'h80);
			wr(8'h60 + 8'(c), 8'h10);
		end
		wr(`A_CFG, 8'h01);
		repeat (700) @(posedge mclk_i);
		for (int c = 0; c < 20; c++) begin
			rd(8'h20 + 8'(c), v);
			check(v, (c == 3) ? 8'hF0 : 8'h20 + 8'(c), "value");
		end
		rd(`A_STAT0, v);
		check(v, 8'h08, "status");
		rd(8'h06, v);
		check(v, 8'h00, "fan status");
		check(int_n, 1'b0, "irq");
		for (int k = 0; k < 4; k++) wr(`A_MASK0 + 8'(k), 8'hFF);
		@(posedge mclk_i);
		check(int_n, 1'b1, "masked");
		for (int k = 0; k < 4; k++) wr(`A_MASK0 + 8'(k), 8'h00);
		@(posedge mclk_i);
		check(int_n, 1'b0, "unmasked");
		rd(8'h38, v);
		check({31'h0, v >= 8'h03 && v <= 8'h05}, 32'h1, "fan count");
		$display("test monitor done");
		ci_i <= 1'b1;
		repeat (4) @(posedge mclk_i);
		ci_i <= 1'b0;
		rd(8'h07, v);
		check(v, 8'h10, "intrusion");
		rst_i <= 1'b1;
		repeat (2) @(posedge mclk_i);
		rst_i <= 1'b0;
		rd(8'h07, v);
		check(v, 8'h10, "intrusion kept");
		wr(8'h07, 8'h10);
		rd(8'h07, v);
		check(v, 8'h00, "intrusion cleared");
		$display("test intrusion done");
		wr(`A_PWM, 8'h80);
		// Let the new duty reach the drive flop before counting a full period
		@(posedge mclk_i);
		cnt = 0;
		repeat (512) begin
			@(posedge mclk_i);
			cnt += {31'h0, pwm_oe};
		end
		check(cnt, 32'd256, "pwm duty");
		wr(`A_PWM, 8'hFF);
		repeat (14) @(posedge mclk_i);
		check(pwm_oe, 1'b0, "pwm off");
		wr(`A_GPOUT, 8'h3C);
		wr(`A_FANCFG, 8'hFF);
		wr(`A_GPOE, 8'hFF);
		wr(`A_CFG, 8'h18);
		repeat (2) @(posedge mclk_i);
		check({fan_oe, fan_o, alarm_oe, alarm_o}, 18'h3FCF3, "gpio");
		$display("test outputs done");
		finish_test();
	end
endmodule // tb_top
